// File: temp_sensor_regs.vh
// Purpose: Shared constants of the temperature sensor serial slave port
// Assumes: Included by bare name from the slave port design file only
// Notes:   Definitions only
`ifndef TEMP_SENSOR_REGS_VH
`define TEMP_SENSOR_REGS_VH

// ----------------------------------------------------------------------
// Bus address and pointer decode
// ----------------------------------------------------------------------
`define ADDR_FIXED_UPPER   4'h9
`define PTR_AMBIENT        2'h0
`define PTR_CONFIG         2'h1
`define PTR_HYSTERESIS     2'h2
`define PTR_LIMIT_SET      2'h3

// ----------------------------------------------------------------------
// Reset values and writable mask
// ----------------------------------------------------------------------
`define RST_AMBIENT        16'h0000
`define RST_CONFIG         8'h00
`define RST_HYSTERESIS     16'h4B00
`define RST_LIMIT_SET      16'h5000
`define LIMIT_WMASK_LSB    8'h80

// ----------------------------------------------------------------------
// Configuration field positions
// ----------------------------------------------------------------------
`define CFG_SHUTDOWN       0
`define CFG_ALERT_POL      2
`define CFG_RES_LO         5
`define CFG_RES_HI         6
`define CFG_ONE_SHOT       7

// ----------------------------------------------------------------------
// Timing: coarsest conversion time and clock rate
// ----------------------------------------------------------------------
`define CONV_BASE_MS       30
`define CLK_FREQ_KHZ       250000
`define CONV_BASE_CYCLES   (`CONV_BASE_MS * `CLK_FREQ_KHZ)

`endif

// File: pin_sync.v
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs asynchronous to clk
// Notes:   Output updates only when stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input  wire             clk,
  input  wire             reset,
  // Pins in, filtered levels out
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] level
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;

  // Stage one feeds stage two only; idle bus level is high
  always @(posedge clk)
  begin
    if (reset)
    begin
      stage1 <= {WIDTH{1'b1}};
      stage2 <= {WIDTH{1'b1}};
      stage3 <= {WIDTH{1'b1}};
    end
    else
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Per bit agreement filter hides a single-cycle glitch
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_filter
      always @(posedge clk)
      begin
        if (reset)
          level[i] <= 1'b1;
        else if (stage2[i] == stage3[i])
          level[i] <= stage3[i];
      end
    end
  endgenerate

endmodule

// File: result_buffer.v
// Purpose: Two-entry valid/ready buffer for converter results
// Assumes: Both sides on clk
// Notes:   in_ready is a flop so upstream sees a clean stall
`timescale 1ns/10ps
module result_buffer #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input  wire             clk,
  input  wire             reset,
  // Filling side
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Draining side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] entry [0:1];
  reg             wr_ptr;
  reg             rd_ptr;
  reg [1:0]       count;
  reg [1:0]       next_count;
  wire            push;
  wire            pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = (count != 2'h0);
  assign out_data  = entry[rd_ptr];

  // Occupancy bookkeeping
  always @*
  begin
    next_count = count;
    if (push & ~pop)
      next_count = count + 2'h1;
    else if (pop & ~push)
      next_count = count - 2'h1;
  end

  // Storage and pointers; full flag registered for the ready output
  always @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr   <= 1'b0;
      rd_ptr   <= 1'b0;
      count    <= 2'h0;
      in_ready <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        entry[wr_ptr] <= in_data;
        wr_ptr        <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      count    <= next_count;
      in_ready <= (next_count != 2'h2);
    end
  end

endmodule

// File: temp_sensor_i2c_slave_port.v
// Purpose: Two-wire slave port and register file of a temperature sensor
// Assumes: scl and sda arrive asynchronously; converter logic on clk
// Notes:   Open-drain data pin; slave only, never drives the clock
`timescale 1ns/10ps
`include "temp_sensor_regs.vh"

module temp_sensor_i2c_slave_port #(
  parameter CONV_BASE_CYCLES = `CONV_BASE_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Two-wire bus pins
  input  wire        scl_pin,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  // Address straps
  input  wire        addr_select_pin_2,
  input  wire        addr_select_pin_1,
  input  wire        addr_select_pin_0,
  // Converter interface
  output reg         conv_start,
  input  wire        conv_valid,
  output wire        conv_ready,
  input  wire [15:0] conv_result,
  // Alert and configuration
  output reg         alert,
  output reg  [7:0]  config_value
);

  // ----------------------------------------------------------------------
  // Bus state machine encoding
  // ----------------------------------------------------------------------
  localparam [2:0] ST_IDLE    = 3'h0;
  localparam [2:0] ST_ADDR    = 3'h1;
  localparam [2:0] ST_ADDR_AK = 3'h2;
  localparam [2:0] ST_WR_BYTE = 3'h3;
  localparam [2:0] ST_WR_AK   = 3'h4;
  localparam [2:0] ST_RD_BYTE = 3'h5;
  localparam [2:0] ST_RD_AK   = 3'h6;

  reg  [2:0]  state;
  reg  [3:0]  bit_cnt;
  reg  [7:0]  rx_shift;
  reg  [7:0]  tx_shift;
  reg  [1:0]  byte_idx;
  reg         rd_lsb;
  reg  [15:0] rd_word;
  reg  [1:0]  register_select_pointer;
  reg  [15:0] ambient_reg;
  reg  [15:0] hysteresis_reg;
  reg  [15:0] limit_set_reg;
  reg         scl_prev;
  reg         sda_prev;
  reg         alert_active;
  reg  [31:0] conv_cnt;
  reg  [15:0] sel_word;
  wire [1:0]  bus_level;
  wire        scl;
  wire        sda;
  wire        scl_rise;
  wire        scl_fall;
  wire        start_cond;
  wire        stop_cond;
  wire [6:0]  own_addr;
  wire        buf_valid;
  wire        buf_ready;
  wire [15:0] buf_data;
  wire [1:0]  res_sel;
  wire [31:0] conv_period;

  // ----------------------------------------------------------------------
  // Pin synchronisers and bus events
  // ----------------------------------------------------------------------
  pin_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk    (clk),
    .reset  (reset),
    .pin_in ({scl_pin, sda_in}),
    .level  (bus_level)
  );

  assign scl = bus_level[1];
  assign sda = bus_level[0];

  // Previous filtered levels give the edges
  always @(posedge clk)
  begin
    if (reset)
    begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_prev <= scl;
      sda_prev <= sda;
    end
  end

  assign scl_rise   = scl & ~scl_prev;
  assign scl_fall   = ~scl & scl_prev;
  assign start_cond = scl & scl_prev & sda_prev & ~sda;
  assign stop_cond  = scl & scl_prev & ~sda_prev & sda;
  assign own_addr   = {`ADDR_FIXED_UPPER, addr_select_pin_2,
                       addr_select_pin_1, addr_select_pin_0};

  // Register selected by the stored pointer
  always @*
  begin
    case (register_select_pointer)
      `PTR_AMBIENT:    sel_word = ambient_reg;
      `PTR_CONFIG:     sel_word = {config_value, config_value};
      `PTR_HYSTERESIS: sel_word = hysteresis_reg;
      default:         sel_word = limit_set_reg;
    endcase
  end

  // ----------------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------------
  // Data line is only changed on clock falls, so it is stable while high
  always @(posedge clk)
  begin
    if (reset)
    begin
      state                   <= ST_IDLE;
      bit_cnt                 <= 4'h0;
      rx_shift                <= 8'h00;
      tx_shift                <= 8'h00;
      byte_idx                <= 2'h0;
      rd_lsb                  <= 1'b0;
      rd_word                 <= 16'h0000;
      sda_out                 <= 1'b0;
      sda_oe                  <= 1'b0;
      register_select_pointer <= 2'h0;
      hysteresis_reg          <= `RST_HYSTERESIS;
      limit_set_reg           <= `RST_LIMIT_SET;
      config_value            <= `RST_CONFIG;
    end
    else
    begin
      sda_out <= 1'b0;
      if (conv_start)
        config_value[`CFG_ONE_SHOT] <= 1'b0;
      if (start_cond)
      begin
        state    <= ST_ADDR;
        bit_cnt  <= 4'h0;
        byte_idx <= 2'h0;
        sda_oe   <= 1'b0;
      end
      else if (stop_cond)
      begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end
      else
      begin
        case (state)
          ST_ADDR, ST_WR_BYTE:
          begin
            if (scl_rise)
            begin
              rx_shift <= {rx_shift[6:0], sda};
              bit_cnt  <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == 4'h8)
            begin
              bit_cnt <= 4'h0;
              if (state == ST_ADDR)
              begin
                if (rx_shift[7:1] == own_addr)
                begin
                  state   <= ST_ADDR_AK;
                  sda_oe  <= 1'b1;
                  rd_word <= sel_word;
                  rd_lsb  <= 1'b0;
                end
                else
                  state <= ST_IDLE;
              end
              else
              begin
                state  <= ST_WR_AK;
                sda_oe <= 1'b1;
                if (byte_idx != 2'h3)
                  byte_idx <= byte_idx + 2'h1;
                if (byte_idx == 2'h0)
                  register_select_pointer <= rx_shift[1:0];
                else
                begin
                  // Only MSB then LSB of the selected register; config takes one byte, ambient none
                  case (register_select_pointer)
                    `PTR_CONFIG:
                      if (byte_idx == 2'h1)
                        config_value <= rx_shift;
                    `PTR_HYSTERESIS:
                      if (byte_idx == 2'h1)
                        hysteresis_reg[15:8] <= rx_shift;
                      else if (byte_idx == 2'h2)
                        hysteresis_reg[7:0] <=
                          rx_shift & `LIMIT_WMASK_LSB;
                    `PTR_LIMIT_SET:
                      if (byte_idx == 2'h1)
                        limit_set_reg[15:8] <= rx_shift;
                      else if (byte_idx == 2'h2)
                        limit_set_reg[7:0] <=
                          rx_shift & `LIMIT_WMASK_LSB;
                    default: ;
                  endcase
                end
              end
            end
          end
          ST_ADDR_AK, ST_WR_AK, ST_RD_AK:
          begin
            if (state == ST_RD_AK && scl_rise && sda)
              state <= ST_IDLE;
            else if (scl_fall)
            begin
              // Acknowledge held low until this fall
              if (state == ST_WR_AK ||
                  (state == ST_ADDR_AK && !rx_shift[0]))
              begin
                state  <= ST_WR_BYTE;
                sda_oe <= 1'b0;
              end
              else
              begin
                state    <= ST_RD_BYTE;
                tx_shift <= {(rd_lsb ? rd_word[6:0] : rd_word[14:8]),
                             1'b0};
                sda_oe   <= rd_lsb ? ~rd_word[7] : ~rd_word[15];
                rd_lsb   <= ~rd_lsb;
              end
            end
          end
          ST_RD_BYTE:
          begin
            if (scl_rise)
              bit_cnt <= bit_cnt + 4'h1;
            else if (scl_fall)
            begin
              if (bit_cnt == 4'h8)
              begin
                bit_cnt <= 4'h0;
                state   <= ST_RD_AK;
                sda_oe  <= 1'b0;
              end
              else
              begin
                sda_oe   <= ~tx_shift[7];
                tx_shift <= {tx_shift[6:0], 1'b0};
              end
            end
          end
          default:
            sda_oe <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Converter results and conversion pacing
  // ----------------------------------------------------------------------
  // Results wait in the buffer while a transaction is in flight
  result_buffer #(
    .WIDTH (16)
  ) u_buffer (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (conv_valid),
    .in_ready  (conv_ready),
    .in_data   (conv_result),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_data)
  );

  assign buf_ready = (state == ST_IDLE);

  // Whole word loaded at once, never half updated
  always @(posedge clk)
  begin
    if (reset)
      ambient_reg <= `RST_AMBIENT;
    else if (buf_valid & buf_ready)
      ambient_reg <= buf_data;
  end

  assign res_sel     = config_value[`CFG_RES_HI:`CFG_RES_LO];
  assign conv_period = CONV_BASE_CYCLES << res_sel;

  // Free-running pace unless shut down; one-shot fires once
  always @(posedge clk)
  begin
    if (reset)
    begin
      conv_cnt   <= 32'h00000000;
      conv_start <= 1'b0;
    end
    else
    begin
      conv_start <= 1'b0;
      if (config_value[`CFG_SHUTDOWN])
      begin
        conv_cnt <= 32'h00000000;
        if (config_value[`CFG_ONE_SHOT] && !conv_start)
          conv_start <= 1'b1;
      end
      else if (conv_cnt >= conv_period - 32'h00000001)
      begin
        conv_cnt   <= 32'h00000000;
        conv_start <= 1'b1;
      end
      else
        conv_cnt <= conv_cnt + 32'h00000001;
    end
  end

  // ----------------------------------------------------------------------
  // Alert comparator with hysteresis
  // ----------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      alert_active <= 1'b0;
      alert        <= 1'b1;
    end
    else
    begin
      if ($signed(ambient_reg) > $signed(limit_set_reg))
        alert_active <= 1'b1;
      else if ($signed(ambient_reg) < $signed(hysteresis_reg))
        alert_active <= 1'b0;
      alert <= config_value[`CFG_ALERT_POL] ? alert_active
                                            : ~alert_active;
    end
  end

endmodule

// File: temp_sensor_port_sva.sv
// Purpose: Port checker of the two-wire slave port
// Assumes: Bus phases of at least 8 clk
// Notes:   Bound to the top module below
`timescale 1ns/10ps
module temp_sensor_port_sva #(
  parameter CONV_BASE_CYCLES = 40
) (
  // Clock and reset
  input wire       clk,
  input wire       reset,
  // Watched ports
  input wire       scl_pin,
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe,
  input wire       conv_start,
  input wire       conv_ready,
  input wire       alert,
  input wire [7:0] config_value
);
  reg        seen;
  reg [15:0] gap;
  reg [7:0]  cfg_q;
  // -----------------------------------------
  // Conversion period
  // -----------------------------------------
  // Restart on config change: the timer may load a new rate mid-period
  always @(posedge clk)
  begin
    cfg_q <= config_value;
    if (reset || config_value != cfg_q)
      seen <= 1'b0;
    else if (conv_start)
      seen <= 1'b1;
    gap <= conv_start ? 16'h0001 : gap + 16'h0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_stop;
    scl_pin && $past(scl_pin) && $rose(sda_in);
  endsequence
  sequence s_ack_high;
    $rose(scl_pin) && sda_oe;
  endsequence
  AST_OUT_LOW: assert property (
    !sda_out) else $error("data output not low");
  AST_STOP_FREE: assert property (
    s_stop |-> ##[1:8] !sda_oe) else $error("bus held after stop");
  AST_ACK_HOLD: assert property (
    s_ack_high |-> sda_oe [*6]) else $error("ack dropped early");
  AST_OE_SCL_LOW: assert property (
    $changed(sda_oe) |-> !scl_pin) else $error("data moved, clock high");
  AST_OE_AFTER_FALL: assert property (
    $rose(sda_oe) |-> $past(scl_pin, 7)) else $error("drive without fall");
  AST_CFG_SCL_LOW: assert property (
    $changed(config_value) |-> !scl_pin) else $error("config write late");
  AST_START_PULSE: assert property (
    conv_start |=> !conv_start) else $error("start pulse too long");
  AST_CONV_PERIOD: assert property (
    conv_start && seen |-> gap == (CONV_BASE_CYCLES << config_value[6:5]))
    else $error("conversion period wrong");
  AST_RESET_VALS: assert property (disable iff (1'b0)
    reset && $past(reset) |-> !sda_oe && !conv_ready && alert
    && config_value == 8'h00) else $error("reset state wrong");
endmodule
bind temp_sensor_i2c_slave_port temp_sensor_port_sva #(
  .CONV_BASE_CYCLES(CONV_BASE_CYCLES)
) chk (
  .clk(clk), .reset(reset), .scl_pin(scl_pin), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .conv_start(conv_start),
  .conv_ready(conv_ready), .alert(alert), .config_value(config_value)
);

// File: bus_master.sv
// Purpose: Behavioural two-wire bus master
// Assumes: Pull-up on the data wire; 16 clk per bit
// Notes:   Open drain: sda_low high pulls the wire down
`timescale 1ns/10ps
module bus_master (
  // Clock
  input  wire clk,
  // Bus wires
  input  wire sda,
  output reg  scl,
  output reg  sda_low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // -----------------------------------------
  // Bus cycles
  // -----------------------------------------
  // Start, or repeated start from a low clock
  task start;
  begin
    repeat (4) @(posedge clk);
    if (!scl)
    begin
      sda_low <= 1'b0;
      repeat (4) @(posedge clk);
      scl <= 1'b1;
      repeat (8) @(posedge clk);
    end
    sda_low <= 1'b1;
    repeat (8) @(posedge clk);
    scl <= 1'b0;
  end
  endtask
  // Data moves mid-low and is sampled mid-high
  task bit_io(input drive_low, output sampled);
  begin
    repeat (4) @(posedge clk);
    sda_low <= drive_low;
    repeat (4) @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    sampled = sda;
    repeat (4) @(posedge clk);
    scl <= 1'b0;
  end
  endtask
  task wr_byte(input [7:0] b, output ack);
    integer i;
    reg     s;
  begin
    for (i = 7; i >= 0; i = i - 1)
      bit_io(~b[i], s);
    bit_io(1'b0, s);
    ack = ~s;
  end
  endtask
  // Ack held low until after the fall, released on the last byte
  task rd_byte(input last, output [7:0] b);
    integer i;
    reg     s;
  begin
    for (i = 7; i >= 0; i = i - 1)
      bit_io(1'b0, b[i]);
    bit_io(~last, s);
  end
  endtask
  task stop;
  begin
    repeat (4) @(posedge clk);
    sda_low <= 1'b1;
    repeat (4) @(posedge clk);
    scl <= 1'b1;
    repeat (8) @(posedge clk);
    sda_low <= 1'b0;
    repeat (16) @(posedge clk);
  end
  endtask
endmodule

// File: tb_temp_sensor_i2c_slave_port.sv
// Purpose: Self-checking bench of the two-wire slave port
// Assumes: Straps at 3'h5; the bench plays the converter
// Notes:   Short conversion period keeps the run brief
`timescale 1ns/10ps
module tb_temp_sensor_i2c_slave_port;
  localparam CONV = 40;
  reg         clk;
  reg         reset;
  reg  [2:0]  pins;
  reg         conv_valid;
  reg  [15:0] conv_result;
  wire        scl;
  wire        sda_low;
  wire        sda_out;
  wire        sda_oe;
  wire        conv_start;
  wire        conv_ready;
  wire        alert;
  wire [7:0]  config_value;
  wire        sda;
  integer     miscompares;
  integer     check_count;
  integer     cycles;
  // Open-drain wire with pull-up
  assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;
  bus_master m (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  temp_sensor_i2c_slave_port #(
    .CONV_BASE_CYCLES(CONV)
  ) dut (
    .clk(clk), .reset(reset), .scl_pin(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin_2(pins[2]),
    .addr_select_pin_1(pins[1]), .addr_select_pin_0(pins[0]),
    .conv_start(conv_start), .conv_valid(conv_valid),
    .conv_ready(conv_ready), .conv_result(conv_result),
    .alert(alert), .config_value(config_value)
  );
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // -----------------------------------------
  // Checks and bus helpers
  // -----------------------------------------
  task check_word(input [15:0] got, input [15:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task check_bit(input got, input exp);
    check_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task wr_regs(input integer n, input [23:0] d);
    integer i;
    reg     a;
  begin
    m.start;
    m.wr_byte({4'h9, pins, 1'b0}, a);
    check_bit(a, 1'b1);
    for (i = 0; i < n; i = i + 1)
    begin
      m.wr_byte(d[23-8*i -: 8], a);
      check_bit(a, 1'b1);
    end
    m.stop;
  end
  endtask
  // Read n bytes, own start first unless rs is set (caller already gave a repeated start)
  task rd_bytes(input integer n, input rs, output [23:0] w);
    integer i;
    reg     a;
  begin
    if (!rs)
      m.start;
    m.wr_byte({4'h9, pins, 1'b1}, a);
    check_bit(a, 1'b1);
    for (i = 0; i < n; i = i + 1)
      m.rd_byte(i == n - 1, w[23-8*i -: 8]);
    check_bit(sda_oe, 1'b0);
    m.stop;
  end
  endtask
  task push(input [15:0] v);
    integer n;
  begin
    @(posedge clk);
    conv_valid <= 1'b1;
    conv_result <= v;
    n = 0;
    @(posedge clk);
    while (conv_ready !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n = n + 1;
    end
    conv_valid <= 1'b0;
  end
  endtask
  // -----------------------------------------
  // Scenarios
  // -----------------------------------------
  task t_regs;
    reg [23:0] w;
  begin
    check_word({8'h00, config_value}, 16'h0000);
    rd_bytes(2, 0, w);
    check_word(w[23:8], 16'h0000);
    wr_regs(1, 24'h030000);
    rd_bytes(2, 0, w);
    check_word(w[23:8], 16'h5000);
    wr_regs(1, 24'h020000);
    rd_bytes(2, 0, w);
    check_word(w[23:8], 16'h4B00);
    wr_regs(3, 24'h031284);
    rd_bytes(2, 0, w);
    check_word(w[23:8], 16'h1280);
    rd_bytes(3, 0, w);
    check_word(w[23:8], 16'h1280);
    check_word({8'h00, w[7:0]}, 16'h0012);
    wr_regs(3, 24'h021000);
    $display("test registers done");
  end
  endtask
  task t_bus;
    integer    i;
    reg        a;
    reg [23:0] w;
  begin
    for (i = 1; i < 9; i = i + 1)
    begin
      m.start;
      m.wr_byte({i[3] ? 4'h1 : 4'h9, pins ^ i[2:0], 1'b0}, a);
      check_bit(a, 1'b0);
      m.wr_byte(8'h03, a);
      check_bit(a, 1'b0);
      m.stop;
    end
    m.start;
    repeat (3) m.bit_io(1'b0, a);
    m.start;
    m.wr_byte({4'h9, pins, 1'b0}, a);
    check_bit(a, 1'b1);
    m.wr_byte(8'h03, a);
    m.start;
    rd_bytes(2, 1, w);
    check_word(w[23:8], 16'h1280);
    $display("test bus done");
  end
  endtask
  task t_buffer;
    reg [23:0] w;
  begin
    wr_regs(3, 24'h00FFFF);
    fork
      rd_bytes(2, 0, w);
      begin
        repeat (300) @(posedge clk);
        push(16'h1A50);
        push(16'h1B00);
        repeat (3) @(posedge clk);
        check_bit(conv_ready, 1'b0);
        push(16'h1C00);
      end
    join
    check_word(w[23:8], 16'h0000);
    repeat (20) @(posedge clk);
    rd_bytes(2, 0, w);
    check_word(w[23:8], 16'h1C00);
    check_bit(alert, 1'b0);
    wr_regs(2, 24'h012400);
    check_word({8'h00, config_value}, 16'h0024);
    repeat (200) @(posedge clk);
    check_bit(alert, 1'b1);
    $display("test buffer done");
  end
  endtask
  task results;
  begin
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  // Hang guard: the tests need about 10000 cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      miscompares = miscompares + 1;
      results;
    end
  end
  initial
  begin
    miscompares = 0;
    check_count = 0;
    cycles = 0;
    reset = 1'b1;
    pins = 3'h5;
    conv_valid = 1'b0;
    conv_result = 16'h0000;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    check_bit(alert, 1'b1);
    t_regs;
    t_bus;
    t_buffer;
    results;
  end
endmodule
